/* File: core_seq_model.sv */
// Core sequencer model that takes requests and runs returns
`timescale 1ns/1ns
module core_seq_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Design side
  input  wire nested_priority_interrupt_pkg::core_out_t coreOut,
  output logic             coreTakeIrq,
  output logic             coreIret,
  output logic      [15:0] popSegment,
  // Bench side
  input  wire logic        takeEn,
  input  wire logic        retReq,
  output logic      [9:0]  seenOps
);
  logic idle;

  // ==========================================================
  // Sequencer is free only in the idle step
  assign idle = coreOut.seqOp == nested_priority_interrupt_pkg::S_IDLE;

  // One-cycle take and return pulses, step record, segment echo
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coreTakeIrq <= 1'b0;
      coreIret    <= 1'b0;
      popSegment  <= 16'h0000;
      seenOps     <= 10'h000;
    end else begin
      coreTakeIrq <= takeEn && coreOut.irqRequest && idle && !coreTakeIrq;
      coreIret    <= retReq && idle && !coreIret;
      seenOps     <= (coreTakeIrq || coreIret) ? 10'h000 : (seenOps | (coreOut.seqOp & 10'h3fe));
      if (coreOut.seqOp == nested_priority_interrupt_pkg::S_CS) popSegment <= coreOut.seqData;
    end
  end
endmodule // core_seq_model

/* File: nested_priority_interrupt_pkg.sv */
// Constants and types of the nested priority interrupt unit
package nested_priority_interrupt_pkg;

  // ==========================================================
  // Register indices and APB byte addresses (index times four)
  localparam logic [7:0]  IDX_CENTRAL   = 8'he6;
  localparam logic [7:0]  IDX_EDGE_SEL  = 8'hf2;
  localparam logic [7:0]  IDX_EXT_PEND  = 8'hf3;
  localparam logic [7:0]  IDX_PAIR_PRI  = 8'hf5;
  localparam logic [7:0]  IDX_VEC_CTRL  = 8'hf6;
  localparam logic [7:0]  IDX_NEST_STK  = 8'hf7;
  localparam logic [7:0]  IDX_EXT_MASK  = 8'hf8;
  localparam logic [7:0]  IDX_PERIPH    = 8'hf9;
  localparam logic [7:0]  IDX_PER_PRI   = 8'hfa;
  localparam logic [7:0]  IDX_SEGMENTS  = 8'hfb;
  localparam logic [7:0]  IDX_STATUS    = 8'hfc;
  localparam logic [11:0] ADDR_CENTRAL  = {2'b00, IDX_CENTRAL, 2'b00};
  localparam logic [11:0] ADDR_EDGE_SEL = {2'b00, IDX_EDGE_SEL, 2'b00};
  localparam logic [11:0] ADDR_EXT_PEND = {2'b00, IDX_EXT_PEND, 2'b00};
  localparam logic [11:0] ADDR_PAIR_PRI = {2'b00, IDX_PAIR_PRI, 2'b00};
  localparam logic [11:0] ADDR_VEC_CTRL = {2'b00, IDX_VEC_CTRL, 2'b00};
  localparam logic [11:0] ADDR_NEST_STK = {2'b00, IDX_NEST_STK, 2'b00};
  localparam logic [11:0] ADDR_EXT_MASK = {2'b00, IDX_EXT_MASK, 2'b00};
  localparam logic [11:0] ADDR_PERIPH   = {2'b00, IDX_PERIPH, 2'b00};
  localparam logic [11:0] ADDR_PER_PRI  = {2'b00, IDX_PER_PRI, 2'b00};
  localparam logic [11:0] ADDR_SEGMENTS = {2'b00, IDX_SEGMENTS, 2'b00};
  localparam logic [11:0] ADDR_STATUS   = {2'b00, IDX_STATUS, 2'b00};

  // ==========================================================
  // Field positions
  localparam int CEN_TOP_PEND = 6;
  localparam int CEN_TOP_MASK = 5;
  localparam int CEN_IEN      = 4;
  localparam int CEN_NESTED   = 3;
  localparam int VEC_A0_SRC   = 0;
  localparam int VEC_D0_SRC   = 1;
  localparam int VEC_TOP_SRC  = 2;
  localparam int VEC_TOP_EDGE = 3;
  localparam int NST_UNMASK   = 7;

  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0]  RST_CENTRAL  = 8'h87;
  localparam logic [7:0]  RST_VEC_CTRL = 8'h05;
  localparam logic [7:0]  RST_PAIR_PRI = 8'hff;
  localparam logic [15:0] RST_PER_PRI  = 16'h7777;
  localparam logic [2:0]  LEVEL_LOWEST = 3'h7;
  localparam int          NUM_EXT      = 8;
  localparam int          NUM_PER      = 4;
  localparam int          NUM_CHAN     = NUM_EXT + NUM_PER;

  // ==========================================================
  // Entry and return step codes, one-hot
  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_PCL  = 10'h002, S_PCH  = 10'h004, S_CS   = 10'h008,
    S_FLG  = 10'h010, S_VEC  = 10'h020, R_FLG  = 10'h040, R_CS   = 10'h080,
    R_PCH  = 10'h100, R_PCL  = 10'h200
  } seq_state_t;

  // Signals toward the core sequencer
  typedef struct packed {
    logic       irqRequest;
    logic       irqTop;
    logic [3:0] irqChannel;
    seq_state_t seqOp;
    logic [15:0] seqData;
    logic       useHandlerSeg;
  } core_out_t;

endpackage

/* File: nested_priority_interrupt_unit.sv */
// Nested priority interrupt unit with APB registers and core entry/return sequencing
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module nested_priority_interrupt_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External pins
  input  wire logic        extPinZero,
  input  wire logic        extPinSix,
  input  wire logic        nmiPin,
  input  wire logic [3:0]  wakePins,
  // On-chip sources
  input  wire logic        timerWdogReq,
  input  wire logic        timerEndCount,
  input  wire logic        clockResetReq,
  input  wire logic [3:0]  periphTrig,
  input  wire logic        coreClkRun,
  input  wire logic        motorNmiClear,
  input  wire logic [3:0]  wakeClear,
  // Core sequencer
  input  wire logic        coreTakeIrq,
  input  wire logic        coreIret,
  input  wire logic [15:0] popSegment,
  output nested_priority_interrupt_pkg::core_out_t coreOut,
  // Notifications
  output logic             motorNmi,
  output logic      [3:0]  wakeFlags
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic [6:0]  prev;
    logic [7:0]  central;
    logic [7:0]  edgeSel;
    logic [7:0]  extPend;
    logic [7:0]  extMask;
    logic [7:0]  pairPri;
    logic [7:0]  vecCtrl;
    logic [6:0]  stack;
    logic        unmask;
    logic [3:0]  perPend;
    logic [3:0]  perMask;
    logic [15:0] perPri;
    logic [15:0] codeSeg;
    logic [15:0] handlerSeg;
    logic        inTop;
    logic [3:0]  depth;
    logic [2:0]  winPri;
    nested_priority_interrupt_pkg::seq_state_t seq;
    nested_priority_interrupt_pkg::core_out_t  out;
    logic        motorNmi;
    logic [3:0]  wakeFlags;
  } state_t;

  state_t st;
  state_t next_st;

  // Combinational scratch
  logic [7:0]  extEvent;
  logic [3:0]  nmiWakeRise;
  logic        topEvent;
  logic        setup;
  logic        wrDo;
  logic        global_irq_enable;
  logic        segEn;
  logic [2:0]  current_priority_level;
  logic [2:0]  lvl;
  logic        req;
  logic        found;
  logic [3:0]  winIdx;
  logic [2:0]  bestPri;
  logic [2:0]  restore;
  logic        restoreHit;
  logic [7:0]  rdByte;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st     = st;
    extEvent    = '0;
    nmiWakeRise = '0;
    topEvent    = 1'b0;
    lvl         = '0;
    req         = 1'b0;
    found       = 1'b0;
    winIdx      = '0;
    bestPri     = nested_priority_interrupt_pkg::LEVEL_LOWEST;
    restore     = nested_priority_interrupt_pkg::LEVEL_LOWEST;
    restoreHit  = 1'b0;
    rdByte      = '0;
    global_irq_enable   = st.central[nested_priority_interrupt_pkg::CEN_IEN];
    segEn = st.central[7];
    current_priority_level   = st.central[2:0];
    // Pins pass two flops: bit0 pin0, 1 pin6, 2 nmi, 6:3 wake
    next_st.sync1 = {wakePins, nmiPin, extPinSix, extPinZero};
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;

    // Channel A0 source and pin edge polarity
    if (st.vecCtrl[nested_priority_interrupt_pkg::VEC_A0_SRC]) begin
      extEvent[0] = st.edgeSel[0] ? (st.sync2[0] & ~st.prev[0])
                                  : (~st.sync2[0] & st.prev[0]);
    end else begin
      extEvent[0] = timerWdogReq;
    end
    // Channel D0 source; other channels have no pin
    if (!st.vecCtrl[nested_priority_interrupt_pkg::VEC_D0_SRC]) begin
      extEvent[6] = st.edgeSel[6] ? (st.sync2[1] & ~st.prev[1])
                                  : (~st.sync2[1] & st.prev[1]);
    end else begin
      extEvent[6] = clockResetReq;
    end
    // Top-level source; the pin source is taken only while the core clock runs
    if (st.vecCtrl[nested_priority_interrupt_pkg::VEC_TOP_SRC]) begin
      topEvent = coreClkRun & (st.vecCtrl[nested_priority_interrupt_pkg::VEC_TOP_EDGE] ?
                 (st.sync2[2] & ~st.prev[2]) : (~st.sync2[2] & st.prev[2]));
    end else begin
      topEvent = timerEndCount;
    end
    // Motor and wake notifications, independent of core clock state
    nmiWakeRise = st.sync2[6:3] & ~st.prev[6:3];
    next_st.motorNmi  = (st.motorNmi & ~motorNmiClear) | (st.sync2[2] & ~st.prev[2]);
    next_st.wakeFlags = (st.wakeFlags & ~wakeClear) | nmiWakeRise;

    // APB access phase
    setup = psel & ~penable;
    wrDo  = psel & penable & st.pready & pwrite & ~st.pslverr;
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = 1'b0;
      case (paddr)
        nested_priority_interrupt_pkg::ADDR_CENTRAL:  rdByte = st.central;
        nested_priority_interrupt_pkg::ADDR_EDGE_SEL: rdByte = st.edgeSel;
        nested_priority_interrupt_pkg::ADDR_EXT_PEND: rdByte = st.extPend;
        nested_priority_interrupt_pkg::ADDR_PAIR_PRI: rdByte = st.pairPri;
        nested_priority_interrupt_pkg::ADDR_VEC_CTRL: rdByte = st.vecCtrl;
        nested_priority_interrupt_pkg::ADDR_NEST_STK: rdByte = {st.unmask, st.stack};
        nested_priority_interrupt_pkg::ADDR_EXT_MASK: rdByte = st.extMask;
        nested_priority_interrupt_pkg::ADDR_PERIPH:   rdByte = {st.perMask, st.perPend};
        nested_priority_interrupt_pkg::ADDR_STATUS:   rdByte = {st.inTop, st.depth, st.winPri};
        nested_priority_interrupt_pkg::ADDR_PER_PRI,
        nested_priority_interrupt_pkg::ADDR_SEGMENTS: rdByte = '0;
        default:                                      next_st.pslverr = 1'b1;
      endcase
      next_st.prdata = {24'h000000, rdByte};
      if (paddr == nested_priority_interrupt_pkg::ADDR_PER_PRI) begin
        next_st.prdata = {16'h0000, st.perPri};
      end
      if (paddr == nested_priority_interrupt_pkg::ADDR_SEGMENTS) begin
        next_st.prdata = {st.handlerSeg, st.codeSeg};
      end
    end
    if (wrDo) begin
      case (paddr)
        nested_priority_interrupt_pkg::ADDR_CENTRAL:  next_st.central = pwdata[7:0];
        nested_priority_interrupt_pkg::ADDR_EDGE_SEL: next_st.edgeSel = pwdata[7:0];
        nested_priority_interrupt_pkg::ADDR_EXT_PEND: next_st.extPend = pwdata[7:0];
        nested_priority_interrupt_pkg::ADDR_PAIR_PRI: next_st.pairPri = pwdata[7:0];
        nested_priority_interrupt_pkg::ADDR_VEC_CTRL: next_st.vecCtrl = pwdata[7:0];
        nested_priority_interrupt_pkg::ADDR_NEST_STK: begin
          next_st.stack  = pwdata[6:0];
          next_st.unmask = st.unmask | pwdata[7];
        end
        nested_priority_interrupt_pkg::ADDR_EXT_MASK: next_st.extMask = pwdata[7:0];
        nested_priority_interrupt_pkg::ADDR_PERIPH: begin
          next_st.perPend = pwdata[3:0];
          next_st.perMask = pwdata[7:4];
        end
        nested_priority_interrupt_pkg::ADDR_PER_PRI:  next_st.perPri = pwdata[15:0];
        nested_priority_interrupt_pkg::ADDR_SEGMENTS: begin
          next_st.codeSeg    = pwdata[15:0];
          next_st.handlerSeg = pwdata[31:16];
        end
        default: ;
      endcase
    end
    // Hardware events win over a software clear in the same cycle
    next_st.extPend = next_st.extPend | extEvent;
    next_st.perPend = next_st.perPend | periphTrig;
    next_st.central[nested_priority_interrupt_pkg::CEN_TOP_PEND] =
      next_st.central[nested_priority_interrupt_pkg::CEN_TOP_PEND] | topEvent;

    // Arbitration over channels; ties go to the lower index
    for (int i = 0; i < nested_priority_interrupt_pkg::NUM_CHAN; i++) begin
      if (i < nested_priority_interrupt_pkg::NUM_EXT) begin
        lvl = {st.pairPri[2*(i/2)+1], st.pairPri[2*(i/2)], 1'(i % 2)};
        req = st.extPend[i] & st.extMask[i] & global_irq_enable;
      end else begin
        lvl = st.perPri[4*(i-8) +: 3];
        req = st.perPend[i-8] & st.perMask[i-8] & global_irq_enable;
      end
      if (req && (!found || lvl < bestPri)) begin
        found   = 1'b1;
        bestPri = lvl;
        winIdx  = 4'(i);
      end
    end
    // Top request overrides; a running top routine blocks everything
    next_st.out.irqTop = ~st.inTop & (st.seq == nested_priority_interrupt_pkg::S_IDLE) &
      st.central[nested_priority_interrupt_pkg::CEN_TOP_PEND] &
      ((st.central[nested_priority_interrupt_pkg::CEN_TOP_MASK] & global_irq_enable) | st.unmask);
    next_st.out.irqRequest = next_st.out.irqTop | (~st.inTop &
      (st.seq == nested_priority_interrupt_pkg::S_IDLE) & found & (bestPri < current_priority_level));
    next_st.out.irqChannel = next_st.out.irqTop ? 4'hf : winIdx;
    if (!next_st.out.irqTop) begin
      next_st.winPri = bestPri;
    end

    // Lowest-indexed saved level for return
    for (int j = 6; j >= 0; j--) begin
      if (st.stack[j]) begin
        restore    = 3'(j);
        restoreHit = 1'b1;
      end
    end

    // Entry and return sequencing
    next_st.out.seqData = '0;
    case (st.seq)
      nested_priority_interrupt_pkg::S_IDLE: begin
        if (coreTakeIrq && st.out.irqRequest) begin
          next_st.seq = nested_priority_interrupt_pkg::S_PCL;
          if (st.out.irqTop) begin
            next_st.inTop = 1'b1;
            next_st.central[nested_priority_interrupt_pkg::CEN_TOP_PEND] = topEvent;
          end else begin
            next_st.central[nested_priority_interrupt_pkg::CEN_IEN] = 1'b0;
            next_st.depth = st.depth + 4'h1;
            if (st.out.irqChannel < 4'(nested_priority_interrupt_pkg::NUM_EXT)) begin
              next_st.extPend[st.out.irqChannel[2:0]] = extEvent[st.out.irqChannel[2:0]];
            end
            if (st.central[nested_priority_interrupt_pkg::CEN_NESTED]) begin
              if (current_priority_level != nested_priority_interrupt_pkg::LEVEL_LOWEST) begin
                next_st.stack[current_priority_level] = 1'b1;
              end
              next_st.central[2:0] = st.winPri;
            end
          end
        end else if (coreIret) begin
          next_st.seq = nested_priority_interrupt_pkg::R_FLG;
        end
      end
      nested_priority_interrupt_pkg::S_PCL: next_st.seq = nested_priority_interrupt_pkg::S_PCH;
      nested_priority_interrupt_pkg::S_PCH: begin
        next_st.seq = segEn ? nested_priority_interrupt_pkg::S_CS
                            : nested_priority_interrupt_pkg::S_FLG;
      end
      nested_priority_interrupt_pkg::S_CS: next_st.seq = nested_priority_interrupt_pkg::S_FLG;
      nested_priority_interrupt_pkg::S_FLG: begin
        next_st.seq = nested_priority_interrupt_pkg::S_VEC;
        next_st.out.seqData = {st.vecCtrl[7:4], st.out.irqChannel, 8'h00} >> 7;
      end
      nested_priority_interrupt_pkg::S_VEC: begin
        next_st.seq = nested_priority_interrupt_pkg::S_IDLE;
        if (segEn) begin
          next_st.codeSeg = st.handlerSeg;
        end
      end
      nested_priority_interrupt_pkg::R_FLG: begin
        next_st.seq = segEn ? nested_priority_interrupt_pkg::R_CS
                            : nested_priority_interrupt_pkg::R_PCH;
      end
      nested_priority_interrupt_pkg::R_CS: begin
        next_st.seq     = nested_priority_interrupt_pkg::R_PCH;
        next_st.codeSeg = popSegment;
      end
      nested_priority_interrupt_pkg::R_PCH: next_st.seq = nested_priority_interrupt_pkg::R_PCL;
      nested_priority_interrupt_pkg::R_PCL: begin
        next_st.seq = nested_priority_interrupt_pkg::S_IDLE;
        if (st.inTop) begin
          next_st.inTop = 1'b0;
        end else begin
          next_st.central[nested_priority_interrupt_pkg::CEN_IEN] = 1'b1;
          if (st.depth != 4'h0) begin
            next_st.depth = st.depth - 4'h1;
          end
          if (st.central[nested_priority_interrupt_pkg::CEN_NESTED]) begin
            next_st.central[2:0] = restore;
            if (restoreHit) begin
              next_st.stack[restore] = 1'b0;
            end
          end
        end
      end
      default: next_st.seq = nested_priority_interrupt_pkg::S_IDLE;
    endcase
    if (st.seq == nested_priority_interrupt_pkg::S_PCH && segEn) begin
      next_st.out.seqData = st.codeSeg;
    end
    next_st.out.seqOp = next_st.seq;
    next_st.out.useHandlerSeg = ~segEn & (next_st.depth != 4'h0);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st         <= '0;
      st.central <= nested_priority_interrupt_pkg::RST_CENTRAL;
      st.vecCtrl <= nested_priority_interrupt_pkg::RST_VEC_CTRL;
      st.pairPri <= nested_priority_interrupt_pkg::RST_PAIR_PRI;
      st.perPri  <= nested_priority_interrupt_pkg::RST_PER_PRI;
      st.winPri  <= nested_priority_interrupt_pkg::LEVEL_LOWEST;
      st.seq     <= nested_priority_interrupt_pkg::S_IDLE;
      st.out.seqOp <= nested_priority_interrupt_pkg::S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign coreOut   = st.out;
  assign motorNmi  = st.motorNmi;
  assign wakeFlags = st.wakeFlags;

  // ==========================================================
  // Checks
  a_stack_push: assert property (@(posedge clk) disable iff (!rstn)
    (st.seq == nested_priority_interrupt_pkg::S_IDLE && coreTakeIrq && st.out.irqRequest &&
     !st.out.irqTop && st.central[3] && st.central[2:0] != 3'h7)
    |=> st.stack[$past(st.central[2:0])])
    else $error("Current level not saved on nested entry");
  a_level_load: assert property (@(posedge clk) disable iff (!rstn)
    (st.seq == nested_priority_interrupt_pkg::S_IDLE && coreTakeIrq && st.out.irqRequest &&
     !st.out.irqTop && st.central[3]) |=> st.central[2:0] == $past(st.winPri))
    else $error("Current level not loaded with acknowledged level");
  a_entry_order: assert property (@(posedge clk) disable iff (!rstn)
    coreOut.seqOp == nested_priority_interrupt_pkg::S_PCL
    |=> coreOut.seqOp == nested_priority_interrupt_pkg::S_PCH)
    else $error("Program counter high byte does not follow low byte");
  a_seg_load: assert property (@(posedge clk) disable iff (!rstn)
    (st.seq == nested_priority_interrupt_pkg::S_VEC && st.central[7])
    |=> st.codeSeg == $past(st.handlerSeg))
    else $error("Code segment not loaded from handler segment");
  a_return_ien: assert property (@(posedge clk) disable iff (!rstn)
    (st.seq == nested_priority_interrupt_pkg::R_PCL && !st.inTop) |=> st.central[4])
    else $error("Global enable not set on return");
  a_unmask_sticky: assert property (@(posedge clk) disable iff (!rstn)
    st.unmask |=> st.unmask)
    else $error("Unmaskable top enable cleared without reset");
  a_top_blocks: assert property (@(posedge clk) disable iff (!rstn)
    st.inTop ##1 st.inTop |-> !coreOut.irqRequest)
    else $error("Request issued during top routine");
  a_top_keeps: assert property (@(posedge clk) disable iff (!rstn)
    (st.inTop && st.seq != nested_priority_interrupt_pkg::S_IDLE && !wrDo)
    |=> $stable(st.central[4:0]) && $stable(st.stack))
    else $error("Top handling changed enable, level or stack");
  a_level7_never: assert property (@(posedge clk) disable iff (!rstn)
    (coreOut.irqRequest && !coreOut.irqTop) |-> st.winPri != 3'h7)
    else $error("Level seven request issued");

endmodule // nested_priority_interrupt_unit

/* File: nested_priority_interrupt_unit_test.sv */
// Testbench for the nested priority interrupt unit
`timescale 1ns/1ns
module nested_priority_interrupt_unit_test;
  localparam logic [11:0] CEN = nested_priority_interrupt_pkg::ADDR_CENTRAL;
  localparam logic [11:0] STK = nested_priority_interrupt_pkg::ADDR_NEST_STK;
  localparam logic [11:0] PER = nested_priority_interrupt_pkg::ADDR_PERIPH;
  localparam logic [11:0] PRI = nested_priority_interrupt_pkg::ADDR_PER_PRI;
  localparam logic [11:0] SEG = nested_priority_interrupt_pkg::ADDR_SEGMENTS;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pinZero = 1'b0, pinSix = 1'b1, takeEn = 1'b0, retReq = 1'b0;
  logic        pready, pslverr, err, coreTakeIrq, coreIret;
  logic [3:0]  trig = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] popSegment;
  logic [9:0]  seenOps;
  nested_priority_interrupt_pkg::core_out_t coreOut;
  int          mismatches = 0, nTests = 0, cyc = 0;

  // ==========================================================
  // Design, core model and clock
  nested_priority_interrupt_unit DUT (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extPinZero(pinZero), .extPinSix(pinSix), .nmiPin(pinZero),
    .wakePins(trig), .timerWdogReq(trig[1]), .timerEndCount(trig[2]),
    .clockResetReq(trig[3]), .periphTrig(trig), .coreClkRun(1'b1), .motorNmiClear(1'b0),
    .wakeClear(4'h0), .coreTakeIrq(coreTakeIrq), .coreIret(coreIret),
    .popSegment(popSegment), .coreOut(coreOut), .motorNmi(), .wakeFlags());
  core_seq_model core (.clk(clk), .rstn(rstn), .coreOut(coreOut), .coreTakeIrq(coreTakeIrq),
    .coreIret(coreIret), .popSegment(popSegment), .takeEn(takeEn), .retReq(retReq),
    .seenOps(seenOps));
  always #2 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      give_verdict;
    end
  end

  // ==========================================================
  // Checking, APB and closing tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task reqchk(input logic exp);
    repeat (3) @(posedge clk);
    chk({31'h0, coreOut.irqRequest}, {31'h0, exp});
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdchk(CEN, 32'h87);
    rdchk(nested_priority_interrupt_pkg::ADDR_VEC_CTRL, 32'h05);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset_values done");
    apb(1'b1, SEG, 32'h00340012);
    apb(1'b1, PRI, 32'h7772);
    apb(1'b1, PER, 32'h10);
    apb(1'b1, CEN, 32'h9d);
    takeEn <= 1'b1;
    @(posedge clk) trig <= 4'h1;
    @(posedge clk) trig <= 4'h0;
    repeat (12) @(posedge clk);
    chk({22'h0, seenOps}, 32'h03e);
    rdchk(CEN, 32'h8a);
    rdchk(STK, 32'h20);
    rdchk(SEG, 32'h00340034);
    apb(1'b1, PER, 32'h10);
    rdchk(PER, 32'h10);
    @(posedge clk) retReq <= 1'b1;
    @(posedge clk) retReq <= 1'b0;
    repeat (12) @(posedge clk);
    chk({22'h0, seenOps}, 32'h3c0);
    rdchk(CEN, 32'h9d);
    rdchk(STK, 32'h00);
    rdchk(SEG, 32'h00340012);
    $display("test nested_entry_return done");
    takeEn <= 1'b0;
    apb(1'b1, PER, 32'h01);
    reqchk(1'b0);
    apb(1'b1, PER, 32'h11);
    reqchk(1'b1);
    apb(1'b1, CEN, 32'h9a);
    reqchk(1'b0);
    apb(1'b1, PRI, 32'h7777);
    apb(1'b1, CEN, 32'h9d);
    reqchk(1'b0);
    apb(1'b1, PER, 32'h00);
    $display("test request_gating done");
    apb(1'b1, nested_priority_interrupt_pkg::ADDR_EDGE_SEL, 32'h01);
    pinZero <= 1'b1;
    pinSix <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(nested_priority_interrupt_pkg::ADDR_EXT_PEND, 32'h41);
    apb(1'b1, STK, 32'h80);
    apb(1'b1, STK, 32'h00);
    rdchk(STK, 32'h80);
    $display("test pins_and_top_enable done");
    apb(1'b1, CEN, 32'hcd);
    reqchk(1'b1);
    takeEn <= 1'b1;
    repeat (10) @(posedge clk);
    takeEn <= 1'b0;
    rdchk(CEN, 32'h8d);
    apb(1'b1, CEN, 32'hcd);
    reqchk(1'b0);
    @(posedge clk) retReq <= 1'b1;
    @(posedge clk) retReq <= 1'b0;
    repeat (12) @(posedge clk);
    rdchk(CEN, 32'hcd);
    rdchk(STK, 32'h80);
    $display("test top_level done");
    give_verdict;
  end
endmodule // nested_priority_interrupt_unit_test
